// *** core/tmd_decoder.sv ***
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// (RULE1) Window keeps the last eight mark bits
// (RULE2) Window shifts on each bit-centre pulse
// (RULE3) Relay track writing blocks window shifting
// (RULE4) Arming bit set only when bit eight is one
// (RULE5) Clear window resets arming and pattern bits
// (RULE6) Pattern gates enabled only while armed
// (RULE7) Six-bit patterns, arming bit excluded
// (RULE8) Sequence register plus patterns decode block marks
// (RULE9) Block mark loads sequence register with 1000
// (RULE10) Start marks shift ones into sequence register
// (RULE11) End marks shift zeros into sequence register
// (RULE12) Sequence register shifts on delayed check pulse
// (RULE13) Write mark track only in relay plus command
// (RULE14) Host starts mark writing from stopped tape
// (RULE15) Six-position ring raises data flag each word
// (RULE16) Buffered word moves to shifter on next flag
// (RULE17) Data track one copies the mark track
// (RULE18) Ring advances on between-bit pulses, six wrap
// (RULE19) Error when ring start and block mark disagree
// (RULE20) Error output only in read/write modes
// (RULE21) Clear window across error-resembling regions
// (RULE22) Block mark seen flag gates early errors
// (RULE23) Timing pulses ignored while delay in progress
// (RULE24) Sticky error bit until mode write or reset
module tmd_decoder
   import tmd_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [31:0] reg_rdata,
   // Tape side inputs
   input  wire logic        mark_bit,
   input  wire logic        bit_centre_pulse,
   input  wire logic        between_bit_pulse,
   input  wire logic        delayed_check_pulse,
   input  wire logic        delay_in_progress,
   // Tape side outputs
   output var  logic        mark_write_bit,
   output var  logic        data1_write_bit,
   output var  logic        track_write_en,
   // Host side outputs
   output var  logic        data_flag,
   output var  logic        mark_track_error,
   output var  logic [3:0]  start_mark_id,
   output var  logic [3:0]  end_mark_id
);

   // Reset release chain
   logic              rst_s1_r;        // First reset stage
   logic              rst_n_r;         // Released reset used everywhere

   // Pin synchronisers, five inputs in one vector
   logic [4:0]        pin_s1_r;        // First stage
   logic [4:0]        pin_s2_r;        // Second stage
   logic [4:0]        pin_s3_r;        // Third stage
   logic [4:0]        pin_lvl_r;       // Agreed level
   logic [4:0]        pin_prev_r;      // Level one cycle earlier
   logic [4:0]        pin_raw;         // Concatenated pins

   // Software state
   tmd_mode_t         mode_r;          // Commanded mode
   logic              relay_r;         // Relay track write mode
   logic [WORD_W-1:0] in_out_buffer;   // Next mark word from host
   logic              err_sticky_r;    // Sticky error bit

   // Track state
   logic [WIN_W-1:0]  window_r;        // Eight pattern bits, bit 7 oldest
   logic              arm_r;           // Ninth arming bit
   logic [SEQ_W-1:0]  mark_sequence_register; // Block mark sequencer
   logic [RING_W-1:0] word_ring_counter;      // One-hot word ring
   logic              block_mark_seen_flag;   // Sync seen since clear
   logic [WORD_W-1:0] shift_r;         // Mark word being written

   // Qualified timing events
   logic              mark_lvl;        // Synchronised mark bit
   logic              tp_centre;       // Valid bit-centre edge
   logic              tp_between;      // Valid between-bit edge
   logic              tp_check;        // Valid delayed check edge
   logic              dip_lvl;         // Synchronised delay in progress

   // Decoding
   logic [PAT_W-1:0]  pattern;         // Six newest window bits
   logic              hit_block;       // Periodic block mark present
   logic              hit_start;       // Start mark present
   logic              hit_end;         // End mark present
   logic              hit_suppress;    // Error-like region present
   logic              clear_window;    // Clear pulse for window and flag
   logic              mode_wr;         // Control register write
   logic              writing;         // Mark track writing enabled
   logic              check_mode;      // Mode that checks errors
   logic              err_event;       // Error detected this cycle
   logic              word_wrap;       // Ring returns to start

   // Reset release through two flip-flops
   always_ff @(posedge clk or negedge arst_n) begin
      // Asserts at once
      if (!arst_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         // Ones walk in
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   assign pin_raw = {delay_in_progress, delayed_check_pulse, between_bit_pulse,
                     bit_centre_pulse, mark_bit};

   // Three-stage synchronisers; a level counts when stages two and three agree
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pin_s1_r   <= 5'h00;
         pin_s2_r   <= 5'h00;
         pin_s3_r   <= 5'h00;
         pin_lvl_r  <= 5'h00;
         pin_prev_r <= 5'h00;
      end else begin
         pin_s1_r   <= pin_raw;
         pin_s2_r   <= pin_s1_r;
         pin_s3_r   <= pin_s2_r;
         // For edge finding
         pin_prev_r <= pin_lvl_r;
         // Moves once stages agree
         for (int i = 0; i < 5; i++) begin
            if (pin_s2_r[i] == pin_s3_r[i]) begin
               pin_lvl_r[i] <= pin_s3_r[i];
            end
         end
      end
   end

   // Rising edges of the timing pulses, dropped while delay is in progress
   assign mark_lvl   = pin_lvl_r[0];
   assign dip_lvl    = pin_lvl_r[4];
   assign tp_centre  = pin_lvl_r[1] & ~pin_prev_r[1] & ~dip_lvl; // RULE23
   assign tp_between = pin_lvl_r[2] & ~pin_prev_r[2] & ~dip_lvl; // RULE23
   assign tp_check   = pin_lvl_r[3] & ~pin_prev_r[3] & ~dip_lvl; // RULE23

   // Mode decode
   assign mode_wr    = reg_wr && (reg_addr == ADDR_CTRL);
   assign writing    = relay_r && (mode_r == TMD_MODE_WRITE_TIMING_MARK_COMMAND); // RULE13
   assign check_mode = (mode_r == TMD_MODE_WRITE) || (mode_r == TMD_MODE_READ) ||
                       (mode_r == TMD_MODE_WRITE_ALL) ||
                       (mode_r == TMD_MODE_READ_ALL); // RULE20

   // Pattern gates see six bits only and need the arming bit
   assign pattern      = window_r[PAT_W-1:0]; // RULE7
   assign hit_block    = arm_r && (pattern == PAT_BLOCK_MARK); // RULE6
   assign hit_start    = arm_r && (pattern == PAT_START_MARK); // RULE6
   assign hit_end      = arm_r && (pattern == PAT_END_MARK); // RULE6
   assign hit_suppress = arm_r && (pattern == PAT_SUPPRESS); // RULE6

   // Window cleared by software, by a new mode, or over error-like regions
   assign clear_window = mode_wr || hit_suppress && tp_check || // RULE21
                         (reg_wr && (reg_addr == ADDR_CTRL) && reg_wdata[CTRL_CLRW_BIT]);

   // Error strobe at the delayed check pulse
   assign err_event = tp_check && check_mode && block_mark_seen_flag && // RULE20 RULE22
                      (word_ring_counter[0] != hit_block); // RULE19

   assign word_wrap = tp_between && word_ring_counter[RING_W-1];

   // Software registers
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mode_r        <= TMD_MODE_MOVE;
         relay_r       <= 1'b0;
         in_out_buffer <= '0;
      end else begin
         // Mode and relay together
         if (mode_wr) begin
            mode_r  <= tmd_mode_t'(reg_wdata[CTRL_MODE_LSB +: 3]);
            relay_r <= reg_wdata[CTRL_RELAY_BIT];
         end
         // Host loads the next mark word after each data flag
         if (reg_wr && (reg_addr == ADDR_BUFFER)) begin
            in_out_buffer <= reg_wdata[WORD_W-1:0]; // RULE16
         end
      end
   end

   // Window register with arming bit
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         window_r <= '0;
         arm_r    <= 1'b0;
      end else if (clear_window) begin
         // Clear beats a shift
         window_r <= '0; // RULE5
         arm_r    <= 1'b0; // RULE5
      end else if (tp_centre && !relay_r) begin // RULE2 RULE3
         // Newest bit at bit 0
         window_r <= {window_r[WIN_W-2:0], mark_lvl}; // RULE1
         // Arm behind a one
         if (window_r[WIN_W-1]) begin
            arm_r <= 1'b1; // RULE4
         end
      end
   end

   // Sequencing register steps at the delayed check pulse
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mark_sequence_register <= '0;
      end else if (tp_check) begin // RULE12
         if (hit_block) begin
            // Reload
            mark_sequence_register <= SEQ_LOAD; // RULE9
         end else if (hit_start) begin
            // Shift in a one
            mark_sequence_register <= {1'b1, mark_sequence_register[SEQ_W-1:1]}; // RULE10
         end else if (hit_end) begin
            // Shift in a zero
            mark_sequence_register <= {1'b0, mark_sequence_register[SEQ_W-1:1]}; // RULE11
         end
      end
   end

   // Decoded mark identities, valid from the delayed check pulse
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         start_mark_id <= '0;
         end_mark_id   <= '0;
      end else if (tp_check) begin
         start_mark_id <= '0;
         end_mark_id   <= '0;
         // Start marks: the state before the step
         // First start sees the loaded 1000
         if (hit_start) begin
            unique case (mark_sequence_register) // RULE8 RULE10
               4'h8:    start_mark_id <= 4'h1;
               4'hc:    start_mark_id <= 4'h2;
               4'he:    start_mark_id <= 4'h4;
               4'hf:    start_mark_id <= 4'h8;
               default: start_mark_id <= 4'h0;
            endcase
         end
         // End marks: prefinal, final, check, spare
         // Ends use the stepped state
         if (hit_end) begin
            unique case ({1'b0, mark_sequence_register[SEQ_W-1:1]}) // RULE8
               4'h7:    end_mark_id <= 4'h1;
               4'h3:    end_mark_id <= 4'h2;
               4'h1:    end_mark_id <= 4'h4;
               4'h0:    end_mark_id <= 4'h8;
               default: end_mark_id <= 4'h0;
            endcase
         end
      end
   end

   // Block mark seen flag; a set in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         block_mark_seen_flag <= 1'b0;
      end else if (hit_block && tp_check) begin
         // Set at check
         block_mark_seen_flag <= 1'b1; // RULE22
      end else if (clear_window) begin
         // Cleared by clear window
         block_mark_seen_flag <= 1'b0; // RULE22
      end
   end

   // Word ring counter, one circulating one
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         word_ring_counter <= RING_INIT; // RULE15
      end else if (tp_between) begin
         // Home again after six
         word_ring_counter <= {word_ring_counter[RING_W-2:0],
                               word_ring_counter[RING_W-1]}; // RULE18
      end
   end

   // Data flag and word shifter for mark writing
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         data_flag <= 1'b0;
         shift_r   <= '0;
      end else begin
         data_flag <= writing && word_wrap; // RULE15
         if (writing && word_wrap) begin
            // Take the buffered word
            shift_r <= in_out_buffer; // RULE16
         end else if (writing && tp_between) begin
            // Next bit to the top
            shift_r <= {shift_r[WORD_W-2:0], 1'b0};
         end
      end
   end

   // Writer outputs; data track one carries the same bit
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mark_write_bit  <= 1'b0;
         data1_write_bit <= 1'b0;
         track_write_en  <= 1'b0;
      end else begin
         // Idle unless writing
         track_write_en  <= writing; // RULE13
         mark_write_bit  <= writing & shift_r[WORD_W-1];
         data1_write_bit <= writing & shift_r[WORD_W-1]; // RULE17
      end
   end

   // Error pulse and sticky bit; a new error beats the clearing mode write
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mark_track_error <= 1'b0;
         err_sticky_r     <= 1'b0;
      end else begin
         mark_track_error <= err_event; // RULE19
         if (err_event) begin
            // Held for software
            err_sticky_r <= 1'b1; // RULE24
         end else if (mode_wr) begin
            // New mode clears it
            err_sticky_r <= 1'b0; // RULE24
         end
      end
   end

   // Read data, valid the cycle after the read strobe
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= '0;
         unique case (reg_addr)
            ADDR_CTRL: begin
               reg_rdata[CTRL_MODE_LSB +: 3] <= mode_r;
               reg_rdata[CTRL_RELAY_BIT]     <= relay_r;
            end
            ADDR_STATUS: begin
               reg_rdata[STAT_ERR_BIT]           <= err_sticky_r;
               reg_rdata[STAT_BMS_BIT]           <= block_mark_seen_flag;
               reg_rdata[STAT_ARM_BIT]           <= arm_r;
               reg_rdata[STAT_WEN_BIT]           <= writing;
               reg_rdata[STAT_SEQ_LSB +: SEQ_W]  <= mark_sequence_register;
            end
            ADDR_TRACK: begin
               reg_rdata[TRK_WIN_LSB +: WIN_W]   <= window_r;
               reg_rdata[TRK_RING_LSB +: RING_W] <= word_ring_counter;
               reg_rdata[TRK_SEQ_LSB +: SEQ_W]   <= mark_sequence_register;
            end
            ADDR_BUFFER: begin
               reg_rdata[WORD_W-1:0] <= in_out_buffer;
            end
            default: begin
               reg_rdata <= '0;
            end
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule : tmd_decoder

`default_nettype wire

// *** core/tmd_pkg.sv ***
package tmd_pkg;

   // Register offsets (byte addresses, one word each)
   localparam logic [3:0] ADDR_CTRL   = 4'h0;  // Mode, relay writing, clear window
   localparam logic [3:0] ADDR_STATUS = 4'h4;  // Flags and error status
   localparam logic [3:0] ADDR_TRACK  = 4'h8;  // Window, sequence and ring state
   localparam logic [3:0] ADDR_BUFFER = 4'hc;  // In-out buffer for the next mark word

   // Control register field positions
   localparam int CTRL_MODE_LSB  = 0;   // Three-bit mode field
   localparam int CTRL_RELAY_BIT = 3;   // Relay track write mode
   localparam int CTRL_CLRW_BIT  = 4;   // Write one to clear the window register

   // Status register field positions
   localparam int STAT_ERR_BIT   = 0;   // Sticky mark track error
   localparam int STAT_BMS_BIT   = 1;   // Block mark seen flag
   localparam int STAT_ARM_BIT   = 2;   // Window arming bit
   localparam int STAT_WEN_BIT   = 3;   // Mark track writing active
   localparam int STAT_SEQ_LSB   = 4;   // Four-bit sequence register copy

   // Track register field positions
   localparam int TRK_WIN_LSB    = 0;   // Eight window bits
   localparam int TRK_RING_LSB   = 8;   // Six ring counter bits
   localparam int TRK_SEQ_LSB    = 16;  // Four sequence bits

   // Widths
   localparam int WIN_W   = 8;          // Window pattern bits
   localparam int PAT_W   = 6;          // Compared pattern length
   localparam int SEQ_W   = 4;          // Sequencing register stages
   localparam int RING_W  = 6;          // Word ring positions
   localparam int WORD_W  = 6;          // Mark word written per word time

   // Reset and load values
   localparam logic [3:0] SEQ_LOAD   = 4'h8;   // Value loaded on a block mark
   localparam logic [5:0] RING_INIT  = 6'h01;  // Initial ring position
   localparam logic [2:0] MODE_RESET = 3'h0;   // Move mode after reset

   // Pattern codes, plain defaults
   localparam logic [5:0] PAT_BLOCK_MARK = 6'h15;  // Periodic block mark
   localparam logic [5:0] PAT_START_MARK = 6'h2a;  // Block start mark
   localparam logic [5:0] PAT_END_MARK   = 6'h33;  // Block end mark
   localparam logic [5:0] PAT_SUPPRESS   = 6'h3c;  // Error-resembling region

   // Bit-centre timing figures
   localparam int CLK_MHZ        = 40;
   localparam int PATTERN_HOLD_US = 33;            // Pattern lifetime between shifts
   localparam int PATTERN_HOLD_CYC = PATTERN_HOLD_US * CLK_MHZ;

   // Mode encodings
   typedef enum logic [2:0] {
      TMD_MODE_MOVE      = 3'h0,
      TMD_MODE_SEARCH    = 3'h1,
      TMD_MODE_READ      = 3'h2,
      TMD_MODE_WRITE     = 3'h3,
      TMD_MODE_WRITE_TIMING_MARK_COMMAND      = 3'h4,
      TMD_MODE_READ_ALL  = 3'h5,
      TMD_MODE_WRITE_ALL = 3'h6,
      TMD_MODE_READ_IN   = 3'h7
   } tmd_mode_t;

endpackage : tmd_pkg

// *** test/tmd_decoder_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none

module tmd_decoder_chk
   import tmd_pkg::*;
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       arst_n,
   // Register strobe
   input wire logic       reg_wr,
   // Tape side
   input wire logic       between_bit_pulse,
   input wire logic       delayed_check_pulse,
   input wire logic       delay_in_progress,
   input wire logic       mark_write_bit,
   input wire logic       data1_write_bit,
   input wire logic       track_write_en,
   // Host side
   input wire logic       data_flag,
   input wire logic       mark_track_error,
   input wire logic [3:0] start_mark_id,
   input wire logic [3:0] end_mark_id
);
   logic [3:0] dc_age_r;   // Cycles since a check pulse rose
   logic [3:0] bb_age_r;   // Cycles since a between-bit pulse rose
   logic [3:0] dip_age_r;  // Cycles the delay condition has held

   // Saturating age counters, so pulses are tied to their cause
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dc_age_r  <= 4'hf;
         bb_age_r  <= 4'hf;
         dip_age_r <= 4'h0;
      end else begin
         dc_age_r  <= $rose(delayed_check_pulse) ? 4'h0 : dc_age_r + {3'h0, dc_age_r != 4'hf};
         bb_age_r  <= $rose(between_bit_pulse) ? 4'h0 : bb_age_r + {3'h0, bb_age_r != 4'hf};
         dip_age_r <= !delay_in_progress ? 4'h0 : dip_age_r + {3'h0, dip_age_r != 4'hf};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_err_at_check: assert property (mark_track_error |-> dc_age_r inside {[1:7]})
      else $error("mark track error away from a check pulse");
   a_ids_at_check: assert property ($changed({start_mark_id, end_mark_id}) |-> dc_age_r inside {[1:7]})
      else $error("mark ids changed away from a check pulse");
   a_flag_at_tick: assert property (data_flag |-> bb_age_r inside {[1:7]})
      else $error("data flag away from a between-bit pulse");
   a_flag_single: assert property (data_flag |=> !data_flag [*8])
      else $error("data flag longer than one pulse");
   a_flag_writing: assert property (data_flag |-> track_write_en)
      else $error("data flag outside mark writing");
   a_wen_cause: assert property ($rose(track_write_en) |-> $past(reg_wr) || $past(reg_wr, 2))
      else $error("writing enabled without a control write");
   a_copy_track: assert property (data1_write_bit == mark_write_bit)
      else $error("data track one differs from mark track");
   a_dip_quiet: assert property (dip_age_r == 4'hf |-> !data_flag && !mark_track_error)
      else $error("pulse acted during delay");
   a_ids_onehot: assert property ($onehot0(start_mark_id) && $onehot0(end_mark_id) && !(|start_mark_id && |end_mark_id))
      else $error("mark ids not one-hot");
   a_err_gated: assert property (mark_track_error |-> !track_write_en)
      else $error("mark track error while writing marks");

   // Main scenarios reached
   c_flag: cover property (data_flag);
   c_err: cover property (mark_track_error);
   c_start_last: cover property (start_mark_id[3]);
   c_end_last: cover property (end_mark_id[3]);

endmodule : tmd_decoder_chk

bind tmd_decoder tmd_decoder_chk i_chk (
   .clk, .arst_n, .reg_wr, .between_bit_pulse, .delayed_check_pulse, .delay_in_progress,
   .mark_write_bit, .data1_write_bit, .track_write_en, .data_flag, .mark_track_error,
   .start_mark_id, .end_mark_id
);

`default_nettype wire

// *** test/tmd_decoder_bench.sv ***
`timescale 1ns/10ps
`default_nettype none

module tmd_decoder_bench
   import tmd_pkg::*;
;
   // Design ports
   logic        clk, arst_n, reg_wr, reg_rd, delay_in_progress;
   logic [3:0]  reg_addr, start_mark_id, end_mark_id;
   logic [31:0] reg_wdata, reg_rdata, r, d;
   logic        mark_bit, bit_centre_pulse, delayed_check_pulse, between_bit_pulse;
   logic        mark_write_bit, data1_write_bit, track_write_en, data_flag, mark_track_error;
   // Expected state of the block
   logic [7:0]  win;
   logic [5:0]  ring, cur, buf_w;
   logic [3:0]  seq, sid, eid;
   logic [2:0]  mode;
   logic        arm, bms, err, relay;
   int          n_fail, checks_done, n_err, n_err_exp, n_flag, n_flag_exp, idx, last;
   integer      seed = 32'ha86a;
   logic [5:0]  corner [12] = '{6'h3f, 6'h15, 6'h2a, 6'h2a, 6'h2a, 6'h2a,
                                6'h33, 6'h33, 6'h33, 6'h33, 6'h3c, 6'h15};

   tmd_decoder i_tmd_decoder (
      .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mark_bit,
      .bit_centre_pulse, .between_bit_pulse, .delayed_check_pulse, .delay_in_progress,
      .mark_write_bit, .data1_write_bit, .track_write_en, .data_flag, .mark_track_error,
      .start_mark_id, .end_mark_id
   );
   tmd_tape_model i_tmd_tape_model (
      .mark_bit, .bit_centre_pulse, .delayed_check_pulse, .between_bit_pulse
   );

   // Clock
   always #12.5 clk = ~clk;

   // Count output pulses
   always @(posedge clk) begin
      if (mark_track_error === 1'b1) n_err++;
      if (data_flag === 1'b1) n_flag++;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   // Register bus cycles
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   // Control write also clears window, flag and sticky error
   task automatic set_ctrl(input logic [2:0] m, input logic rel);
      wr(ADDR_CTRL, {27'h0, 1'b1, rel, m});
      {mode, relay, win, arm, bms, err} = {m, rel, 11'h0};
   endtask : set_ctrl

   function automatic logic [3:0] id_of(input logic [3:0] s, a, b, c, e);
      return {s == e, s == c, s == b, s == a};
   endfunction : id_of

   // Expected effect of one bit cell
   function automatic void model_bit(input logic b);
      logic [5:0] p;
      if (delay_in_progress) return;
      if (!relay) begin
         arm = arm | win[7];
         win = {win[6:0], b};
      end
      p = arm ? win[5:0] : 6'h00;
      {sid, eid} = 8'h00;
      if (bms && mode inside {3'h2, 3'h3, 3'h5, 3'h6} && (ring[0] ^ (p == PAT_BLOCK_MARK))) begin
         err = 1'b1;
         n_err_exp++;
      end
      if (p == PAT_SUPPRESS) begin
         {win, arm, bms} = 10'h0;
      end else if (p == PAT_BLOCK_MARK) begin
         {seq, bms} = {SEQ_LOAD, 1'b1};
      end else if (p == PAT_START_MARK) begin
         sid = id_of(seq, 4'h8, 4'hc, 4'he, 4'hf);
         seq = {1'b1, seq[3:1]};
      end else if (p == PAT_END_MARK) begin
         seq = {1'b0, seq[3:1]};
         eid = id_of(seq, 4'h7, 4'h3, 4'h1, 4'h0);
      end
      if (relay && mode == TMD_MODE_WRITE_TIMING_MARK_COMMAND && ring[5]) n_flag_exp++;
      ring = {ring[4:0], ring[5]};
   endfunction : model_bit

   task automatic compare_all();
      check("start id", {28'h0, sid}, {28'h0, start_mark_id});
      check("end id", {28'h0, eid}, {28'h0, end_mark_id});
      rd(ADDR_TRACK, d);
      check("track", {12'h0, seq, 2'h0, ring, win}, d);
      rd(ADDR_STATUS, d);
      check("status", {24'h0, seq, relay && mode == TMD_MODE_WRITE_TIMING_MARK_COMMAND, arm, bms, err}, d);
   endtask : compare_all

   task automatic step(input logic b);
      i_tmd_tape_model.send_bit(b);
      model_bit(b);
      compare_all();
   endtask : step

   task automatic send_word(input logic [5:0] w);
      for (int i = 5; i >= 0; i--) step(w[i]);
   endtask : send_word

   // Watchdog
   initial begin
      #(25 * 60000);
      n_fail++;
      tally_and_finish();
   end

   initial begin
      {clk, arst_n, reg_wr, reg_rd, delay_in_progress} = '0;
      {reg_addr, reg_wdata} = '0;
      {win, arm, bms, err, relay, seq, sid, eid, mode} = '0;
      ring = RING_INIT;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      compare_all();
      wr(4'h2, 32'hffffffff);
      rd(4'h2, d);
      check("unmapped", 32'h0, d);
      // Every mode, corner marks then random words with delays
      for (int m = 0; m < 8; m++) begin
         set_ctrl(m[2:0], 1'b0);
         n_err = 0;
         n_err_exp = 0;
         foreach (corner[i]) send_word(corner[i]);
         repeat (4) begin
            r = $random(seed);
            @(posedge clk) delay_in_progress <= (r[9:8] == 2'h0);
            send_word(r[5:0]);
            @(posedge clk) delay_in_progress <= 1'b0;
         end
         check("error pulses", n_err_exp, n_err);
      end
      // Mark writing, started while the transport is stopped
      @(posedge clk) delay_in_progress <= 1'b1;
      r = $random(seed);
      buf_w = r[5:0];
      wr(ADDR_BUFFER, {26'h0, buf_w});
      set_ctrl(TMD_MODE_WRITE_TIMING_MARK_COMMAND, 1'b1);
      step(1'b1);
      check("write enable", 32'h1, {31'h0, track_write_en});
      @(posedge clk) delay_in_progress <= 1'b0;
      {n_flag, n_flag_exp, idx, last} = {32'd0, 32'd0, 32'd6, 32'd0};
      repeat (19) begin
         r = $random(seed);
         step(r[0]);
         if (n_flag != last) begin
            last = n_flag;
            cur = buf_w;
            idx = 0;
            buf_w = r[13:8];
            wr(ADDR_BUFFER, {26'h0, buf_w});
         end
         if (idx < 6) begin
            check("mark bit", {31'h0, cur[5 - idx]}, {31'h0, mark_write_bit});
            check("track one", {31'h0, cur[5 - idx]}, {31'h0, data1_write_bit});
            idx++;
         end
      end
      check("data flags", n_flag_exp, n_flag);
      tally_and_finish();
   end

endmodule : tmd_decoder_bench

`default_nettype wire

// *** test/tmd_tape_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module tmd_tape_model (
   // Read level and recovered timing pulses
   output var logic mark_bit,
   output var logic bit_centre_pulse,
   output var logic delayed_check_pulse,
   output var logic between_bit_pulse
);
   // Pulses stand still between bit cells
   initial begin
      {mark_bit, bit_centre_pulse, delayed_check_pulse, between_bit_pulse} = '0;
   end

   // One bit cell: centre, check, then between-bit, 100 ns pulses 200 ns apart
   task send_bit(input logic b);
      #7 mark_bit = b;
      #100 bit_centre_pulse = 1'b1;
      #100 bit_centre_pulse = 1'b0;
      #100 delayed_check_pulse = 1'b1;
      #100 delayed_check_pulse = 1'b0;
      // Past its hold time the level is no longer kept
      mark_bit = ~b;
      #100 between_bit_pulse = 1'b1;
      #100 between_bit_pulse = 1'b0;
      #100;
   endtask : send_bit

endmodule : tmd_tape_model

`default_nettype wire
